// [design/dws_pkg.sv]
// Constants, encodings and carrier types for the write-burst sequencer.
package dws_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  REG_MODE    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_COUNT   = 4'h8;
  localparam int          MODE_LSB    = 0;
  localparam int          PRE2_BIT    = 2;
  localparam int          CWL_LSB     = 8;
  localparam int          CWL_W       = 5;
  localparam int          AL_LSB      = 16;
  localparam int          AL_W        = 6;
  localparam int          ST_CCD      = 0;
  localparam int          ST_CWL      = 1;
  localparam int          ST_WTR      = 2;
  localparam int          ST_CHOP     = 3;

  // ****************************************************************
  // Reset values and timing counts in link clocks
  // ****************************************************************
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [4:0]  CWL_RST     = 5'h09;
  localparam logic [5:0]  AL_RST      = 6'h00;
  localparam logic [4:0]  CWL_MIN     = 5'h09;
  localparam logic [7:0]  CCD_BAD_PRE2 = 8'h05;
  localparam logic [7:0]  WTR_S_CK    = 8'h02;
  localparam logic [7:0]  WTR_L_CK    = 8'h06;
  localparam int          WL_DEPTH    = 64;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BM_FIXED8 = 2'b00,
    BM_OTF    = 2'b01,
    BM_FIXED4 = 2'b10,
    BM_RSVD   = 2'b11
  } dws_bmode_t;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ  = 2'b10,
    CMD_OTHER = 2'b11
  } dws_cmd_t;

  typedef enum logic {
    BS_IDLE = 1'b0,
    BS_DATA = 1'b1
  } dws_bstate_t;

  typedef struct packed {
    dws_cmd_t   kind;
    logic [1:0] bg;
    logic       a12;
  } dws_pin_t;

  typedef struct packed {
    logic       vld;
    logic       chop;
    logic [1:0] bg;
  } dws_slot_t;

endpackage

// [design/dws_write_seq.sv]
// Write-burst sequencer of the memory device: burst length choice, latency and spacing checks.
`timescale 1ns/100ps
`default_nettype none

module dws_write_seq #(
  parameter int          DQ_W   = 8,
  parameter int          DEPTH  = dws_pkg::WL_DEPTH,
  parameter logic [7:0]  WTR_S  = dws_pkg::WTR_S_CK,
  parameter logic [7:0]  WTR_L  = dws_pkg::WTR_L_CK
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          ck,
  input  wire dws_pkg::dws_pin_t             cmd_pin,
  input  wire logic [DQ_W-1:0]               dq,
  input  wire logic [dws_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [dws_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [dws_pkg::DATA_W-1:0]    reg_rdata,
  output logic      [DQ_W-1:0]               beat_data,
  output logic                               beat_valid,
  output logic      [2:0]                    beat_index,
  output logic      [1:0]                    beat_group
);

  // ****************************************************************
  // Pin synchronisers and link clock edges
  // ****************************************************************
  // Command and data pass the same two stages as the clock, so their relation to the edges is kept.
  logic                 ck_s1, ck_s2, ck_d;
  dws_pkg::dws_pin_t    pin_s1, pin_s2;
  logic [DQ_W-1:0]      dq_s1, dq_s2;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ck_s1  <= 1'b0;
      ck_s2  <= 1'b0;
      ck_d   <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      dq_s1  <= '0;
      dq_s2  <= '0;
    end
    else
    begin
      ck_s1  <= ck;
      ck_s2  <= ck_s1;
      ck_d   <= ck_s2;
      pin_s1 <= cmd_pin;
      pin_s2 <= pin_s1;
      dq_s1  <= dq;
      dq_s2  <= dq_s1;
    end
  end

  wire ck_rise = ck_s2 & ~ck_d;
  wire ck_fall = ~ck_s2 & ck_d;

  // ****************************************************************
  // Mode register and decode
  // ****************************************************************
  dws_pkg::dws_bmode_t                bmode;
  logic                               pre2;
  logic [dws_pkg::CWL_W-1:0]          write_cas_latency;
  logic [dws_pkg::AL_W-1:0]           al;
  logic [3:0]                         status;
  logic [dws_pkg::DATA_W-1:0]         wr_count;

  wire wr_mode   = reg_wr && (reg_addr == dws_pkg::REG_MODE);
  wire wr_status = reg_wr && (reg_addr == dws_pkg::REG_STATUS);
  // Commands other than write and read are taken without complaint at any time.
  wire wr_cmd    = ck_rise && (pin_s2.kind == dws_pkg::CMD_WRITE);
  wire rd_cmd    = ck_rise && (pin_s2.kind == dws_pkg::CMD_READ);
  // The reserved mode code falls back to eight-beat bursts.
  wire chop_sel  = (bmode == dws_pkg::BM_FIXED4) ||
                   ((bmode == dws_pkg::BM_OTF) && !pin_s2.a12);

  // Latency of zero cannot be scheduled and is treated as one clock; ones beyond DEPTH saturate at DEPTH.
  wire [6:0] wl_sum = 7'({2'h0, write_cas_latency}) + 7'({1'h0, al});
  wire [6:0] wl_cap = (wl_sum > 7'(DEPTH)) ? 7'(DEPTH) : wl_sum;
  wire [6:0] wl_idx = (wl_cap == 7'h00) ? 7'h00 : wl_cap - 7'h01;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bmode <= dws_pkg::dws_bmode_t'(dws_pkg::MODE_RST);
      pre2  <= 1'b0;
      write_cas_latency   <= dws_pkg::CWL_RST;
      al    <= dws_pkg::AL_RST;
    end
    else if (wr_mode)
    begin
      bmode <= dws_pkg::dws_bmode_t'(reg_wdata[dws_pkg::MODE_LSB +: 2]);
      pre2  <= reg_wdata[dws_pkg::PRE2_BIT];
      write_cas_latency   <= reg_wdata[dws_pkg::CWL_LSB +: dws_pkg::CWL_W];
      al    <= reg_wdata[dws_pkg::AL_LSB +: dws_pkg::AL_W];
    end
  end

  // ****************************************************************
  // Latency delay line, one slot per link clock
  // ****************************************************************
  // A slot is loaded at the write's position and reaches slot 0 one clock before its data start.
  // Writes every four clocks each get their own slot, so gapless bursts need no extra queue.
  dws_pkg::dws_slot_t pend [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_slot
      dws_pkg::dws_slot_t shift_in;
      if (gi == DEPTH - 1)
      begin : g_top
        assign shift_in = '0;
      end
      else
      begin : g_mid
        assign shift_in = pend[gi+1];
      end
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          pend[gi] <= '0;
        else if (ck_rise)
        begin
          if (wr_cmd && (wl_idx == 7'(gi)))
            pend[gi] <= '{vld: 1'b1, chop: chop_sel, bg: pin_s2.bg};
          else
            pend[gi] <= shift_in;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Burst capture: even beats on rising, odd beats on falling edges
  // ****************************************************************
  dws_pkg::dws_bstate_t bstate;
  logic [2:0]           beat;
  logic                 bchop;
  logic [1:0]           bbg;

  wire start     = ck_rise && pend[0].vld;
  wire last_beat = bchop ? (beat == 3'h3) : (beat == 3'h7);
  wire burst_end = ck_rise && (bstate == dws_pkg::BS_DATA) && last_beat;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bstate     <= dws_pkg::BS_IDLE;
      beat       <= 3'h0;
      bchop      <= 1'b0;
      bbg        <= 2'h0;
      beat_valid <= 1'b0;
      beat_data  <= '0;
      beat_index <= 3'h0;
      beat_group <= 2'h0;
    end
    else
    begin
      beat_valid <= 1'b0;
      if (start)
      begin
        // A new burst may begin on the very edge that closes the previous one.
        bstate     <= dws_pkg::BS_DATA;
        beat       <= 3'h0;
        bchop      <= pend[0].chop;
        bbg        <= pend[0].bg;
        beat_valid <= 1'b1;
        beat_data  <= dq_s2;
        beat_index <= 3'h0;
        beat_group <= pend[0].bg;
      end
      else
      begin
        case (bstate)
          dws_pkg::BS_IDLE:
          begin
            bstate <= dws_pkg::BS_IDLE;
          end
          dws_pkg::BS_DATA:
          begin
            if (burst_end)
              bstate <= dws_pkg::BS_IDLE;
            else if ((ck_rise || ck_fall) && !last_beat)
            begin
              beat       <= beat + 3'h1;
              beat_valid <= 1'b1;
              beat_data  <= dq_s2;
              beat_index <= beat + 3'h1;
              beat_group <= bbg;
            end
          end
          default:
          begin
            bstate <= dws_pkg::BS_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Spacing monitors
  // ****************************************************************
  // Violations by the controller are only flagged; the device still takes the command.
  logic [7:0] gap_cnt;
  logic [7:0] wtr_cnt;
  logic       wtr_run;
  logic [1:0] wtr_bg;

  wire [7:0] wtr_need = (pin_s2.bg == wtr_bg) ? WTR_L : WTR_S;
  wire set_ccd = wr_cmd && pre2 && (gap_cnt == dws_pkg::CCD_BAD_PRE2);
  wire set_cwl = wr_cmd && pre2 && (write_cas_latency <= dws_pkg::CWL_MIN);
  wire set_wtr = rd_cmd && wtr_run && (wtr_cnt < wtr_need);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      gap_cnt <= 8'h00;
      wtr_cnt <= 8'h00;
      wtr_run <= 1'b0;
      wtr_bg  <= 2'h0;
    end
    else if (ck_rise)
    begin
      if (wr_cmd)
        gap_cnt <= 8'h01;
      else if ((gap_cnt != 8'h00) && (gap_cnt != 8'hFF))
        gap_cnt <= gap_cnt + 8'h01;
      if (burst_end)
      begin
        // The clock that closes the burst is the zero point of the delay. The count is compared one clock
        // after it is stored, so it starts at one and a read then sees the rises since that clock.
        wtr_cnt <= 8'h01;
        wtr_run <= 1'b1;
        wtr_bg  <= bbg;
      end
      else if (wtr_cnt != 8'hFF)
        wtr_cnt <= wtr_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Status, counter and register read port
  // ****************************************************************
  wire [3:0] st_set = {1'b0, set_wtr, set_cwl, set_ccd};
  wire [3:0] st_clr = wr_status ? reg_wdata[3:0] : 4'h0;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      status   <= 4'h0;
      wr_count <= '0;
    end
    else
    begin
      // An error arriving with its clear stays set.
      status[2:0] <= st_set[2:0] | (status[2:0] & ~st_clr[2:0]);
      if (wr_cmd)
      begin
        status[dws_pkg::ST_CHOP] <= chop_sel;
        wr_count <= wr_count + 32'h1;
      end
    end
  end

  logic [dws_pkg::DATA_W-1:0] rd_mux;
  always_comb
  begin
    if (reg_addr == dws_pkg::REG_MODE)
      rd_mux = {10'h000, al, 3'h0, write_cas_latency, 5'h00, pre2, bmode};
    else if (reg_addr == dws_pkg::REG_STATUS)
      rd_mux = {28'h0000000, status};
    else if (reg_addr == dws_pkg::REG_COUNT)
      rd_mux = wr_count;
    else
      rd_mux = 32'h00000000;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
  end

endmodule

`default_nettype wire

// [sim/dws_write_seq_assertions.sv]
// Port-level checks of the write-burst sequencer.
`timescale 1ns/100ps
`default_nettype none
module dws_write_seq_assertions #(
  parameter int DQ_W = 8
) (
  input wire logic                         sys_clk,
  input wire logic                         reset,
  input wire logic                         ck,
  input wire dws_pkg::dws_pin_t            cmd_pin,
  input wire logic [DQ_W-1:0]              dq,
  input wire logic [dws_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [dws_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [dws_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic [DQ_W-1:0]              beat_data,
  input wire logic                         beat_valid,
  input wire logic [2:0]                   beat_index,
  input wire logic [1:0]                   beat_group
);
  logic [1:0] mode;
  logic [2:0] prev_idx;
  logic [1:0] prev_grp;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mode     <= dws_pkg::MODE_RST;
      prev_idx <= 3'h0;
      prev_grp <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == dws_pkg::REG_MODE)
        mode <= reg_wdata[1:0];
      if (beat_valid)
      begin
        prev_idx <= beat_index;
        prev_grp <= beat_group;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_chop_beat_limit: assert property (beat_valid && mode == dws_pkg::BM_FIXED4 |-> beat_index < 3'h4)
    else $error("chopped burst stored a fifth beat");
  a_beat_order: assert property (beat_valid && beat_index != 3'h0 |-> beat_index == prev_idx + 3'h1)
    else $error("beat index skipped");
  a_second_beat_due: assert property (beat_valid && beat_index == 3'h0 |-> ##[3:5] beat_valid && beat_index == 3'h1)
    else $error("second beat late");
  a_full_burst_on: assert property (beat_valid && beat_index == 3'h3 && mode == dws_pkg::BM_FIXED8
    |-> ##[3:5] beat_valid && beat_index == 3'h4)
    else $error("eight-beat burst stopped at four");
  a_beat_one_cycle: assert property (beat_valid |=> !beat_valid)
    else $error("beat pulse too long");
  a_group_held: assert property (beat_valid && beat_index != 3'h0 |-> beat_group == prev_grp)
    else $error("bank group changed in a burst");
  a_mode_readback: assert property (reg_rd && reg_addr == dws_pkg::REG_MODE |=> reg_rdata[1:0] == mode)
    else $error("burst mode reads back wrong");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");
  c_full: cover property (beat_valid && beat_index == 3'h7);
  c_chop: cover property (beat_valid && mode == dws_pkg::BM_FIXED4 && beat_index == 3'h3);
  c_stat: cover property (reg_rd && reg_addr == dws_pkg::REG_STATUS);
endmodule
`default_nettype wire

// [sim/dws_ctrl_model.sv]
// Memory controller model: free link clock, command pins and a counting data pattern.
`timescale 1ns/100ps
`default_nettype none
module dws_ctrl_model #(
  parameter int DQ_W = 8
) (
  output var logic                ck,
  output var dws_pkg::dws_pin_t   cmd_pin,
  output var logic [DQ_W-1:0]     dq
);
  int edge_n;
  int last_rise;
  initial
  begin
    ck      = 1'b0;
    edge_n  = 0;
    dq      = '0;
    cmd_pin = '{dws_pkg::CMD_NONE, 2'h0, 1'b0};
    #37;
    forever #100 ck = ~ck;
  end
  // Data change every half clock, so a beat taken at a wrong edge shows a wrong value.
  always @(posedge ck or negedge ck)
  begin
    edge_n = edge_n + 1;
    #50 dq = DQ_W'(edge_n + 1);
  end
  // Commands change on the falling edge so they stand still around the rising edge.
  task automatic send(input dws_pkg::dws_cmd_t kind, input logic [1:0] bg, input logic a12, input int gap);
    repeat (gap - 1)
    begin
      @(negedge ck);
      cmd_pin = '{dws_pkg::CMD_NONE, 2'h0, 1'b0};
    end
    @(negedge ck);
    cmd_pin = '{kind, bg, a12};
    @(posedge ck);
    #1 last_rise = edge_n;
  endtask
endmodule
`default_nettype wire

// [sim/dws_write_seq_bench.sv]
// Self-checking bench of the write-burst sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module dws_write_seq_bench;
  localparam int DQ_W = 8;
  logic                        sys_clk;
  logic                        reset;
  logic                        ck;
  dws_pkg::dws_pin_t           cmd_pin;
  logic [DQ_W-1:0]             dq;
  logic [DQ_W-1:0]             beat_data;
  logic [3:0]                  reg_addr;
  logic [31:0]                 reg_wdata;
  logic [31:0]                 reg_rdata;
  logic                        reg_wr;
  logic                        reg_rd;
  logic                        beat_valid;
  logic [2:0]                  beat_index;
  logic [1:0]                  beat_group;
  logic [12:0]                 beats[$];
  int                          num_errors = 0;
  int                          total_checks = 0;
  int                          e;
  int                          f;
  dws_write_seq #(.DQ_W(DQ_W)) dut (.sys_clk, .reset, .ck, .cmd_pin, .dq, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .beat_data, .beat_valid, .beat_index, .beat_group);
  dws_ctrl_model #(.DQ_W(DQ_W)) ctl (.ck, .cmd_pin, .dq);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (beat_valid === 1'b1)
      beats.push_back({beat_group, beat_index, beat_data});
  function automatic logic [31:0] mv(logic [1:0] m, logic p2, int write_cas_latency, int al);
    return {10'h0, al[5:0], 3'h0, write_cas_latency[4:0], 5'h0, p2, m};
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  // Beat i of a write taken at edge w carries the pattern value of edge w + 2*wl + i.
  task automatic chk_burst(input int w, input int wl, input int len, input logic [1:0] bg, input bit last);
    logic [12:0] b;
    for (int i = 0; i < len; i++)
    begin
      b = (beats.size() > 0) ? beats.pop_front() : 'x;
      `CHK(b, {bg, i[2:0], DQ_W'(w + 2 * wl + i)})
    end
    if (last)
      `CHK(beats.size(), 0)
  endtask
  task automatic t_reset;
    rreg(dws_pkg::REG_MODE, mv(2'h0, 1'b0, 9, 0));
    rreg(dws_pkg::REG_STATUS, 32'h0);
    wreg(4'hC, 32'hFFFFFFFF);
    rreg(4'hC, 32'h0);
  endtask
  task automatic t_modes;
    logic [1:0] m[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic       a[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int         n[4] = '{8, 8, 4, 4};
    for (int k = 0; k < 4; k++)
    begin
      wreg(dws_pkg::REG_MODE, mv(m[k], 1'b0, 9, 0));
      beats.delete();
      ctl.send(dws_pkg::CMD_WRITE, 2'(k), a[k], 2);
      e = ctl.last_rise;
      ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 16);
      chk_burst(e, 9, n[k], 2'(k), 1'b1);
      rreg(dws_pkg::REG_STATUS, {28'h0, n[k] == 4, 3'h0});
    end
  endtask
  task automatic t_b2b;
    wreg(dws_pkg::REG_MODE, mv(2'h1, 1'b0, 10, 2));
    beats.delete();
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 2);
    e = ctl.last_rise;
    ctl.send(dws_pkg::CMD_OTHER, 2'h0, 1'b0, 2);
    ctl.send(dws_pkg::CMD_WRITE, 2'h2, 1'b0, 2);
    f = ctl.last_rise;
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 20);
    chk_burst(e, 12, 8, 2'h1, 1'b0);
    chk_burst(f, 12, 4, 2'h2, 1'b1);
    rreg(dws_pkg::REG_COUNT, 32'h6);
  endtask
  task automatic t_pre2;
    wreg(dws_pkg::REG_MODE, mv(2'h0, 1'b1, 9, 0));
    ctl.send(dws_pkg::CMD_WRITE, 2'h0, 1'b1, 2);
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 16);
    rreg(dws_pkg::REG_STATUS, 32'h2);
    wreg(dws_pkg::REG_STATUS, 32'hF);
    wreg(dws_pkg::REG_MODE, mv(2'h0, 1'b1, 10, 0));
    beats.delete();
    ctl.send(dws_pkg::CMD_WRITE, 2'h0, 1'b1, 2);
    e = ctl.last_rise;
    ctl.send(dws_pkg::CMD_WRITE, 2'h0, 1'b1, 6);
    f = ctl.last_rise;
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 20);
    chk_burst(e, 10, 8, 2'h0, 1'b0);
    chk_burst(f, 10, 8, 2'h0, 1'b1);
    rreg(dws_pkg::REG_STATUS, 32'h0);
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 2);
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 5);
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 20);
    rreg(dws_pkg::REG_STATUS, 32'h1);
    wreg(dws_pkg::REG_STATUS, 32'hF);
    rreg(dws_pkg::REG_STATUS, 32'h0);
  endtask
  // The burst of a write at rise 0 ends at rise 13 when the latency is 9.
  task automatic t_wtr;
    wreg(dws_pkg::REG_MODE, mv(2'h0, 1'b0, 9, 0));
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 2);
    ctl.send(dws_pkg::CMD_READ, 2'h1, 1'b0, 18);
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 4);
    rreg(dws_pkg::REG_STATUS, 32'h4);
    wreg(dws_pkg::REG_STATUS, 32'hF);
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 2);
    ctl.send(dws_pkg::CMD_READ, 2'h2, 1'b0, 15);
    ctl.send(dws_pkg::CMD_WRITE, 2'h1, 1'b1, 20);
    ctl.send(dws_pkg::CMD_READ, 2'h1, 1'b0, 19);
    ctl.send(dws_pkg::CMD_NONE, 2'h0, 1'b0, 4);
    rreg(dws_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    reset     = 1'b1;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_modes;
    t_b2b;
    t_pre2;
    t_wtr;
    results;
  end
  // The run needs about 53 us; the limit leaves ample margin.
  initial
  begin
    #200us;
    num_errors++;
    results;
  end
endmodule
bind dws_write_seq dws_write_seq_assertions #(.DQ_W(DQ_W)) chk (.sys_clk, .reset, .ck, .cmd_pin, .dq,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .beat_data, .beat_valid, .beat_index, .beat_group);
`default_nettype wire
